// ---- egs_pkg.sv ----
// constants and register map of the electronic gear scaler
package egs_pkg;

    // ------------------------------------------------------------
    // parameter addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_DENOM    = 16'h2606;
    localparam logic [15:0] ADDR_NUMER    = 16'h2608;
    localparam logic [15:0] ADDR_DIR      = 16'h260A;
    localparam logic [15:0] ADDR_PRESET   = 16'h260C;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [31:0] RST_DENOM     = 32'h0000_0001;
    localparam logic [31:0] RST_NUMER     = 32'h0000_0001;
    localparam logic [15:0] RST_DIR       = 16'h0003;
    localparam logic [15:0] RST_PRESET    = 16'h0000;
    localparam logic [15:0] PRESET_MAX    = 16'h000B;
    localparam logic [15:0] DIR_MIN       = 16'h0001;
    localparam logic [15:0] DIR_MAX       = 16'h0003;

    // ------------------------------------------------------------
    // direction filter fields
    // ------------------------------------------------------------
    localparam int          DIR_POS_BIT   = 0;
    localparam int          DIR_NEG_BIT   = 1;

    // motor increments per revolution
    localparam logic [31:0] MOTOR_PER_REV = 32'h0002_0000;

    // ------------------------------------------------------------
    // preset reference increments per revolution, codes 1 to 11
    // ------------------------------------------------------------
    localparam logic [31:0] PRESET_1      = 32'h0000_00C8;
    localparam logic [31:0] PRESET_2      = 32'h0000_0190;
    localparam logic [31:0] PRESET_3      = 32'h0000_01F4;
    localparam logic [31:0] PRESET_4      = 32'h0000_03E8;
    localparam logic [31:0] PRESET_5      = 32'h0000_07D0;
    localparam logic [31:0] PRESET_6      = 32'h0000_0FA0;
    localparam logic [31:0] PRESET_7      = 32'h0000_1388;
    localparam logic [31:0] PRESET_8      = 32'h0000_2710;
    localparam logic [31:0] PRESET_9      = 32'h0000_1000;
    localparam logic [31:0] PRESET_10     = 32'h0000_2000;
    localparam logic [31:0] PRESET_11     = 32'h0000_4000;

endpackage : egs_pkg

// ---- egs_gear_scaler.sv ----
// electronic gear scaler: reference increments to motor setpoint
// ------------------------------------------------------------
// What this block does
// - each reference increment is turned into motor increments by numerator over denominator.
// - selector zero uses the programmed numerator and denominator.
// - selector codes 1 to 11 pick 200,400,500,1000,2000,4000,5000,10000,4096,8192,16384 per revolution.
// - a preset ratio moves the motor one full revolution for the selected number of reference increments.
// - a negative numerator reverses the motor direction against the reference.
// - after reset the ratio is 1:1 with numerator 1, denominator 1 and selector 0.
// - movement in a disabled direction is suppressed.
// - direction filter 1 is positive only, 2 negative only, 3 both, default 3.
// - the motor has 131072 increments per revolution, the basis of the presets.
// - each scaled reference change in an enabled direction is added to the motor setpoint on the next clock edge.
// ------------------------------------------------------------
`timescale 1ns/1ns

module egs_gear_scaler
(
    input  wire logic               clock,
    input  wire logic               rst,
    // decoded reference increments
    input  wire logic               ref_step,
    input  wire logic               ref_neg,
    // parameter port
    input  wire logic               par_wr,
    input  wire logic               par_rd,
    input  wire logic [15:0]        par_addr,
    input  wire logic [31:0]        par_wdata,
    output logic      [31:0]        par_rdata,
    output logic                    par_ack,
    // motor setpoint
    output logic signed [63:0]      setpoint_pos,
    output logic signed [33:0]      move_delta,
    output logic                    move_valid,
    output logic                    move_blocked
);

    // ------------------------------------------------------------
    // parameter registers
    // ------------------------------------------------------------
    logic signed [31:0] ratio_denominator_r;
    logic signed [31:0] ratio_numerator_r;
    logic        [15:0] allowed_direction_r;
    logic        [15:0] preset_scale_select_r;

    // ------------------------------------------------------------
    // write decode; out-of-range values are dropped
    // ------------------------------------------------------------
    function automatic logic upper_clear(input logic [31:0] word);
        return (word[31:16] == 16'h0000);
    endfunction : upper_clear

    function automatic logic fits16(input logic [31:0] word, input logic [15:0] hi);
        return upper_clear(word) && (word[15:0] <= hi);
    endfunction : fits16

    logic               wr_denom;
    logic               wr_numer;
    logic               wr_dir;
    logic               wr_preset;

    always_comb
    begin
        wr_denom  = par_wr && (par_addr == egs_pkg::ADDR_DENOM) && ($signed(par_wdata) > 32'sh0000_0000);
        wr_numer  = par_wr && (par_addr == egs_pkg::ADDR_NUMER);
        wr_dir    = par_wr && (par_addr == egs_pkg::ADDR_DIR) && fits16(par_wdata, egs_pkg::DIR_MAX)
                    && (par_wdata[15:0] >= egs_pkg::DIR_MIN);
        wr_preset = par_wr && (par_addr == egs_pkg::ADDR_PRESET) && fits16(par_wdata, egs_pkg::PRESET_MAX);
    end

    // ------------------------------------------------------------
    // ratio denominator
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ratio_denominator_r <= egs_pkg::RST_DENOM;
        end
        else if (wr_denom)
        begin
            ratio_denominator_r <= par_wdata;
        end
    end

    // ------------------------------------------------------------
    // ratio numerator, sign kept
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ratio_numerator_r <= egs_pkg::RST_NUMER;
        end
        else if (wr_numer)
        begin
            ratio_numerator_r <= par_wdata;
        end
    end

    // ------------------------------------------------------------
    // direction filter
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            allowed_direction_r <= egs_pkg::RST_DIR;
        end
        else if (wr_dir)
        begin
            allowed_direction_r <= par_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // preset selector
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            preset_scale_select_r <= egs_pkg::RST_PRESET;
        end
        else if (wr_preset)
        begin
            preset_scale_select_r <= par_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // parameter read back, one cycle after the strobe
    // ------------------------------------------------------------
    function automatic logic [31:0] zext16(input logic [15:0] half);
        return {16'h0000, half};
    endfunction : zext16

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            par_ack <= 1'b0;
        end
        else
        begin
            par_ack <= par_rd | par_wr;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            par_rdata <= 32'h0000_0000;
        end
        else if (par_rd)
        begin
            unique case (par_addr)
                egs_pkg::ADDR_DENOM:  par_rdata <= ratio_denominator_r;
                egs_pkg::ADDR_NUMER:  par_rdata <= ratio_numerator_r;
                egs_pkg::ADDR_DIR:    par_rdata <= zext16(allowed_direction_r);
                egs_pkg::ADDR_PRESET: par_rdata <= zext16(preset_scale_select_r);
                default:              par_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // preset denominator lookup
    // ------------------------------------------------------------
    function automatic logic [31:0] preset_denom(input logic [15:0] sel);
        logic [31:0] d;
        d = egs_pkg::RST_DENOM;
        unique case (sel)
            16'h0001: d = egs_pkg::PRESET_1;
            16'h0002: d = egs_pkg::PRESET_2;
            16'h0003: d = egs_pkg::PRESET_3;
            16'h0004: d = egs_pkg::PRESET_4;
            16'h0005: d = egs_pkg::PRESET_5;
            16'h0006: d = egs_pkg::PRESET_6;
            16'h0007: d = egs_pkg::PRESET_7;
            16'h0008: d = egs_pkg::PRESET_8;
            16'h0009: d = egs_pkg::PRESET_9;
            16'h000A: d = egs_pkg::PRESET_10;
            16'h000B: d = egs_pkg::PRESET_11;
            default:  d = egs_pkg::RST_DENOM;
        endcase
        return d;
    endfunction : preset_denom

    // ------------------------------------------------------------
    // effective ratio and scaling
    // ------------------------------------------------------------
    logic signed [33:0] num_eff;
    logic signed [33:0] den_eff;
    logic signed [33:0] step_num;
    logic signed [33:0] rem_r;
    logic signed [33:0] sum;
    logic signed [33:0] quo;
    logic signed [33:0] rem_nxt;
    logic               dir_ok;
    logic               step_take;
    logic               step_drop;

    // ------------------------------------------------------------
    // ratio selection
    // ------------------------------------------------------------
    always_comb
    begin
        if (preset_scale_select_r == egs_pkg::RST_PRESET)
        begin
            num_eff = 34'(ratio_numerator_r);
            den_eff = 34'(ratio_denominator_r);
        end
        else
        begin
            num_eff = $signed({2'b00, egs_pkg::MOTOR_PER_REV});
            den_eff = $signed({2'b00, preset_denom(preset_scale_select_r)});
        end
    end

    // ------------------------------------------------------------
    // scaling with remainder carry
    // ------------------------------------------------------------
    always_comb
    begin
        step_num = ref_neg ? -num_eff : num_eff;
        sum      = rem_r + step_num;
        quo      = sum / den_eff;
        rem_nxt  = sum - 34'(quo * den_eff);
    end

    // ------------------------------------------------------------
    // direction filter on the sign of the motor delta
    // ------------------------------------------------------------
    always_comb
    begin
        dir_ok    = (quo > 34'sd0) ? allowed_direction_r[egs_pkg::DIR_POS_BIT] :
                    (quo < 34'sd0) ? allowed_direction_r[egs_pkg::DIR_NEG_BIT] : 1'b1;
        step_take = ref_step && dir_ok;
        step_drop = ref_step && !dir_ok;
    end

    // ------------------------------------------------------------
    // remainder carry
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rem_r <= 34'sd0;
        end
        else if (step_take)
        begin
            rem_r <= rem_nxt;
        end
    end

    // ------------------------------------------------------------
    // setpoint accumulation
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            setpoint_pos <= 64'sd0;
        end
        else if (step_take)
        begin
            setpoint_pos <= setpoint_pos + 64'(quo);
        end
    end

    // ------------------------------------------------------------
    // last applied delta, zero after a suppressed step
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            move_delta <= 34'sd0;
        end
        else if (step_take)
        begin
            move_delta <= quo;
        end
        else if (step_drop)
        begin
            move_delta <= 34'sd0;
        end
    end

    // ------------------------------------------------------------
    // step outcome pulses
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            move_valid   <= 1'b0;
            move_blocked <= 1'b0;
        end
        else
        begin
            move_valid   <= step_take;
            move_blocked <= step_drop;
        end
    end

endmodule : egs_gear_scaler

// ---- egs_ref_src.sv ----
// reference increment source model
`timescale 1ns/1ns
module egs_ref_src
(
    input  wire logic clock,
    input  wire logic run,
    input  wire logic neg,
    output logic      ref_step = 1'b0,
    output logic      ref_neg = 1'b0
);
    // idle direction line flips so no stale level is seen
    always @(negedge clock)
    begin
        ref_step <= run;
        ref_neg  <= run ? neg : ~ref_neg;
    end
endmodule : egs_ref_src

// ---- egs_sva.sv ----
// port checker of the gear scaler
`timescale 1ns/1ns
module egs_sva
(
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               ref_step,
    input wire logic               ref_neg,
    input wire logic               par_wr,
    input wire logic               par_rd,
    input wire logic               par_ack,
    input wire logic               move_valid,
    input wire logic               move_blocked,
    input wire logic [15:0]        par_addr,
    input wire logic [31:0]        par_wdata,
    input wire logic [31:0]        par_rdata,
    input wire logic signed [63:0] setpoint_pos,
    input wire logic signed [33:0] move_delta
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_step; ref_step; endsequence
    sequence s_answer; ##1 (move_valid ^ move_blocked); endsequence
    property p_ack; par_wr || par_rd |=> par_ack; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_ack_src; par_ack |-> $past(par_wr || par_rd); endproperty
    a_ack_src: assert property (p_ack_src) else $error("ack without request");
    property p_step; s_step |-> s_answer; endproperty
    a_step: assert property (p_step) else $error("step not answered");
    property p_quiet; !ref_step |=> !move_valid && !move_blocked && $stable(setpoint_pos); endproperty
    a_quiet: assert property (p_quiet) else $error("setpoint moved without step");
    property p_accum; move_valid |-> setpoint_pos == $past(setpoint_pos) + move_delta; endproperty
    a_accum: assert property (p_accum) else $error("setpoint not advanced by delta");
    property p_block; move_blocked |-> move_delta == 34'sh0 && $stable(setpoint_pos); endproperty
    a_block: assert property (p_block) else $error("blocked step moved");
    property p_unmap; par_rd && par_addr[15:8] != 8'h26 |=> par_rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rd_hold; !par_rd |=> $stable(par_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
endmodule : egs_sva
bind egs_gear_scaler egs_sva u_sva (.clock, .rst, .ref_step, .ref_neg, .par_wr, .par_rd, .par_ack, .move_valid,
    .move_blocked, .par_addr, .par_wdata, .par_rdata, .setpoint_pos, .move_delta);

// ---- tb.sv ----
// self-checking bench of the gear scaler
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
    logic               clock = 1'b0, rst = 1'b1, run = 1'b0, neg = 1'b0, par_wr = 1'b0, par_rd = 1'b0;
    logic               ref_step, ref_neg, par_ack, move_valid, move_blocked;
    logic        [15:0] par_addr = 16'h0000;
    logic        [31:0] par_wdata = 32'h0, par_rdata;
    logic signed [63:0] setpoint_pos, exp_pos = 64'sh0;
    logic signed [33:0] move_delta;
    logic        [31:0] pv [1:11] = '{32'hC8, 32'h190, 32'h1F4, 32'h3E8, 32'h7D0, 32'hFA0, 32'h1388,
                                      32'h2710, 32'h1000, 32'h2000, 32'h4000};
    int                 errors = 0, checks = 0, c;

    initial
    begin
        forever #25 clock = ~clock;
    end

    egs_ref_src u_src (.clock, .run, .neg, .ref_step, .ref_neg);
    egs_gear_scaler dut (.clock, .rst, .ref_step, .ref_neg, .par_wr, .par_rd, .par_addr, .par_wdata,
        .par_rdata, .par_ack, .setpoint_pos, .move_delta, .move_valid, .move_blocked);

    task end_sim;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // one parameter access; a read compares against d
    task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        par_wr    <= w;
        par_rd    <= ~w;
        par_addr  <= a;
        par_wdata <= d;
        @(negedge clock);
        par_wr <= 1'b0;
        par_rd <= 1'b0;
        for (i = 0; i < 4 && par_ack !== 1'b1; i++)
            @(negedge clock);
        errors += (i == 4);
        if (i == 4)
            end_sim();
        if (!w)
            `CHK("rdata", d, par_rdata)
        @(negedge clock);
    endtask : acc

    // n increments from the source, then the setpoint moved by dl
    task steps(input logic [31:0] n, input logic ng, input logic signed [63:0] dl);
        run <= 1'b1;
        neg <= ng;
        repeat (n) @(negedge clock);
        run <= 1'b0;
        repeat (2) @(negedge clock);
        exp_pos = exp_pos + dl;
        `CHK("setpoint", exp_pos, setpoint_pos)
    endtask : steps

    initial
    begin
        repeat (12) @(negedge clock);
        rst <= 1'b0;
        @(negedge clock);
        acc(1'b0, egs_pkg::ADDR_DENOM, 32'h1);
        acc(1'b0, egs_pkg::ADDR_NUMER, 32'h1);
        acc(1'b0, egs_pkg::ADDR_DIR, 32'h3);
        acc(1'b0, egs_pkg::ADDR_PRESET, 32'h0);
        acc(1'b0, 16'h1000, 32'h0);
        steps(32'h3, 1'b1, -64'sh3);
        acc(1'b1, egs_pkg::ADDR_NUMER, 32'h3);
        acc(1'b1, egs_pkg::ADDR_DENOM, 32'h2);
        steps(32'h3, 1'b0, 64'sh4);
        acc(1'b1, egs_pkg::ADDR_NUMER, 32'hFFFF_FFFD);
        steps(32'h3, 1'b0, -64'sh4);
        acc(1'b1, egs_pkg::ADDR_DIR, 32'h1);
        steps(32'h3, 1'b0, 64'sh0);
        `CHK("delta", 34'sh0, move_delta)
        acc(1'b1, egs_pkg::ADDR_DIR, 32'h2);
        steps(32'h4, 1'b0, -64'sh6);
        acc(1'b1, egs_pkg::ADDR_DIR, 32'h3);
        acc(1'b1, egs_pkg::ADDR_DIR, 32'h0);
        acc(1'b0, egs_pkg::ADDR_DIR, 32'h3);
        acc(1'b1, egs_pkg::ADDR_DENOM, 32'h0);
        acc(1'b0, egs_pkg::ADDR_DENOM, 32'h2);
        for (c = 1; c <= 11; c++)
        begin
            acc(1'b1, egs_pkg::ADDR_PRESET, c);
            steps(pv[c], 1'b0, 64'sh2_0000);
        end
        acc(1'b1, egs_pkg::ADDR_PRESET, 32'hC);
        acc(1'b0, egs_pkg::ADDR_PRESET, 32'hB);
        end_sim();
    end
endmodule : tb
